// ---- hw/port_group_pkg.sv ----
// Purpose : Constants, register map and carrier types for the port group config block
// Assumes : 50 MHz device clock, AXI4-Lite register access with 32-bit data
// Notes   : Register indices are word indices; byte address is four times the index
package port_group_pkg;

   // ---------------------------------------------------------------
   // Bus and register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W        = 16;
   localparam int          DATA_W        = 32;
   localparam logic [13:0] IDX_FPC_LOW   = 14'h00F1;
   localparam logic [13:0] IDX_TSC_LOW   = 14'h00F2;
   localparam logic [13:0] IDX_FPC_HIGH  = 14'h20F1;
   localparam logic [13:0] IDX_TCR_HIGH  = 14'h20F0;
   localparam logic [13:0] IDX_LATCH_EN  = 14'h3000;
   localparam logic [13:0] IDX_PIN_STAT  = 14'h3001;
   localparam logic [15:0] ADDR_FPC_LOW  = {IDX_FPC_LOW, 2'b00};
   localparam logic [15:0] ADDR_TSC_LOW  = {IDX_TSC_LOW, 2'b00};
   localparam logic [15:0] ADDR_FPC_HIGH = {IDX_FPC_HIGH, 2'b00};
   localparam logic [15:0] ADDR_TCR_HIGH = {IDX_TCR_HIGH, 2'b00};
   localparam logic [15:0] ADDR_LATCH_EN = {IDX_LATCH_EN, 2'b00};
   localparam logic [15:0] ADDR_PIN_STAT = {IDX_PIN_STAT, 2'b00};
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  MASK_FPC      = 8'hF7;
   localparam logic [7:0]  MASK_TCR      = 8'hEF;
   localparam logic [7:0]  MASK_TSC      = 8'h03;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int IO_PIN_OUTPUT_SELECT_LSB   = 5;
   localparam int GPIO_OE_BIT = 3;
   localparam int GANGED_BIT  = 2;
   localparam int LATCH_BIT   = 1;
   localparam int INHIBIT_BIT = 0;
   localparam int IBO_LSB     = 6;
   localparam int BACKPLANE_CLOCK_SELECT_LSB   = 4;
   localparam int RXSYNC_BIT  = 2;
   localparam int TXCH_BIT    = 1;
   localparam int RXCH_BIT    = 0;
   localparam int TSDIR_BIT   = 1;
   localparam int TSSEL_BIT   = 0;

   // ---------------------------------------------------------------
   // Field codes
   // ---------------------------------------------------------------
   localparam logic [2:0] GPIO_FRAME_LOSS  = 3'h0;
   localparam logic [2:0] GPIO_CLOCK_LOSS  = 3'h1;
   localparam logic [2:0] GPIO_SIG_FREEZE  = 3'h2;
   localparam logic [2:0] GPIO_FRAMER_LOS  = 3'h3;
   localparam logic [2:0] GPIO_ANALOG_LOS  = 3'h4;
   localparam logic [2:0] GPIO_ALL_LOW     = 3'h5;
   localparam logic [2:0] GPIO_ALL_HIGH    = 3'h6;
   localparam logic [1:0] IBO_DISABLED     = 2'h0;

   // ---------------------------------------------------------------
   // Backplane clock synthesis (phase accumulator)
   // ---------------------------------------------------------------
   localparam longint      CLK_HZ       = 50000000;
   localparam int          NCO_W        = 32;
   localparam longint      BP_HZ_2M048  = 2048000;
   localparam longint      BP_HZ_4M096  = 4096000;
   localparam longint      BP_HZ_8M192  = 8192000;
   localparam longint      BP_HZ_16M384 = 16384000;
   localparam logic [31:0] BP_INC_2M048  = 32'((BP_HZ_2M048 << NCO_W) / CLK_HZ);
   localparam logic [31:0] BP_INC_4M096  = 32'((BP_HZ_4M096 << NCO_W) / CLK_HZ);
   localparam logic [31:0] BP_INC_8M192  = 32'((BP_HZ_8M192 << NCO_W) / CLK_HZ);
   localparam logic [31:0] BP_INC_16M384 = 32'((BP_HZ_16M384 << NCO_W) / CLK_HZ);

   typedef struct packed {
      logic [7:0] frame_loss;
      logic [7:0] clock_loss;
      logic [7:0] sig_freeze;
      logic [7:0] framer_los;
      logic [7:0] analog_los;
   } alarm_group_type;

endpackage

// ---- hw/global_port_group_config.sv ----
// Purpose : Global pin-function and bus configuration for a group of framer ports
// Assumes : All pin inputs synchronous to clk; AXI4-Lite master keeps one write and one read
// Notes   : Every output comes from a flip-flop, so pin functions follow a write by two edges
`timescale 1ns/1ps
`default_nettype none

module global_port_group_config
   import port_group_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [ADDR_W-1:0]     awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [DATA_W-1:0]     wdata,
   input  wire logic [DATA_W/8-1:0]   wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [ADDR_W-1:0]     araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [DATA_W-1:0]          rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   input  wire alarm_group_type       alarms_high,
   input  wire logic [7:0]            gpio_in,
   output logic [7:0]                 gpio_out,
   output logic [7:0]                 gpio_oe,
   input  wire logic                  irq_request,
   output logic                       irq_pin_n,
   output logic                       ganged_bus_enable,
   output logic [1:0]                 interleave_mode_low,
   output logic [1:0]                 interleave_mode_high,
   output logic                       ibo_mux_enable_low,
   output logic                       ibo_mux_enable_high,
   output logic [1:0]                 backplane_clk,
   output logic [7:0]                 counter_latch_pulse,
   input  wire logic [15:0]           rx_frame_pulse,
   input  wire logic [15:0]           rx_multiframe_pulse,
   input  wire logic [15:0]           tx_slot_block,
   input  wire logic [15:0]           tx_slot_clock,
   input  wire logic [15:0]           rx_slot_block,
   input  wire logic [15:0]           rx_slot_clock,
   output logic [15:0]                rx_sync_pin,
   output logic [15:0]                tx_slot_pin,
   output logic [15:0]                rx_slot_pin,
   input  wire logic [7:0]            tx_sync_framer,
   input  wire logic [7:0]            tx_sync_framer_oe,
   input  wire logic [7:0]            system_sync_source,
   input  wire logic [7:0]            tx_system_sync_pin_in,
   output logic [7:0]                 tx_system_sync_pin,
   output logic [7:0]                 tx_system_sync_pin_oe
);

   // ---------------------------------------------------------------
   // Register storage and bus state
   // ---------------------------------------------------------------
   logic [7:0]        fpc_low_r;
   logic [7:0]        tsc_low_r;
   logic [7:0]        fpc_high_r;
   logic [7:0]        tcr_high_r;
   logic [7:0]        latch_en_r;
   logic              aw_held_r;
   logic              w_held_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [7:0]        w_byte_r;
   logic              w_lane_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic              arready_r;
   logic              rvalid_r;
   logic [1:0]        rresp_r;
   logic [DATA_W-1:0] rdata_r;
   logic              do_write;
   logic              wr_hit;
   logic              rd_hit;
   logic [DATA_W-1:0] rd_data;
   logic              run_r;

   assign awready = awready_r;
   assign wready  = wready_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign arready = arready_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   // Address and data are captured independently; the response waits for both
   assign do_write = aw_held_r && w_held_r && !bvalid_r;

   always_comb
   begin
      wr_hit = 1'b0;
      unique case (aw_addr_r)
         ADDR_FPC_LOW, ADDR_TSC_LOW, ADDR_FPC_HIGH, ADDR_TCR_HIGH, ADDR_LATCH_EN:
            wr_hit = 1'b1;
         default:
            wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end
      else if (awvalid && awready_r)
      begin
         awready_r <= 1'b0;
         aw_held_r <= 1'b1;
         aw_addr_r <= awaddr;
      end
      else if (bvalid_r && bready)
         aw_held_r <= 1'b0;
      else if (!aw_held_r)
         awready_r <= 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wready_r <= 1'b0;
         w_held_r <= 1'b0;
         w_byte_r <= 8'h00;
         w_lane_r <= 1'b0;
      end
      else if (wvalid && wready_r)
      begin
         wready_r <= 1'b0;
         w_held_r <= 1'b1;
         w_byte_r <= wdata[7:0];
         w_lane_r <= wstrb[0];
      end
      else if (bvalid_r && bready)
         w_held_r <= 1'b0;
      else if (!w_held_r)
         wready_r <= 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_r && bready)
         bvalid_r <= 1'b0;
   end

   // Reserved positions are masked on write so they never steer a pin
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         fpc_low_r  <= REG_RESET;
         tsc_low_r  <= REG_RESET;
         fpc_high_r <= REG_RESET;
         tcr_high_r <= REG_RESET;
         latch_en_r <= REG_RESET;
      end
      else if (do_write && w_lane_r)
      begin
         unique case (aw_addr_r)
            ADDR_FPC_LOW:  fpc_low_r  <= w_byte_r & MASK_FPC;
            ADDR_TSC_LOW:  tsc_low_r  <= w_byte_r & MASK_TSC;
            ADDR_FPC_HIGH: fpc_high_r <= w_byte_r & MASK_FPC;
            ADDR_TCR_HIGH: tcr_high_r <= w_byte_r & MASK_TCR;
            ADDR_LATCH_EN: latch_en_r <= w_byte_r;
            default:       latch_en_r <= latch_en_r;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   always_comb
   begin
      rd_hit  = 1'b1;
      rd_data = '0;
      unique case (araddr)
         ADDR_FPC_LOW:  rd_data[7:0]  = fpc_low_r;
         ADDR_TSC_LOW:  rd_data[7:0]  = tsc_low_r;
         ADDR_FPC_HIGH: rd_data[7:0]  = fpc_high_r;
         ADDR_TCR_HIGH: rd_data[7:0]  = tcr_high_r;
         ADDR_LATCH_EN: rd_data[7:0]  = latch_en_r;
         ADDR_PIN_STAT: rd_data[15:0] = {tx_system_sync_pin_in, gpio_in};
         default:       rd_hit        = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
      end
      else if (arvalid && arready_r)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rdata_r   <= rd_data;
      end
      else if (rvalid_r && rready)
         rvalid_r <= 1'b0;
      else if (!rvalid_r)
         arready_r <= 1'b1;
   end

   // ---------------------------------------------------------------
   // General-purpose pins of the upper ports
   // ---------------------------------------------------------------
   // Reserved select code drives low rather than leaving pins floating
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gpio_oe  <= 8'h00;
         gpio_out <= 8'h00;
      end
      else
      begin
         gpio_oe <= {8{tcr_high_r[GPIO_OE_BIT]}};
         unique case (tcr_high_r[IO_PIN_OUTPUT_SELECT_LSB +: 3])
            GPIO_FRAME_LOSS: gpio_out <= alarms_high.frame_loss;
            GPIO_CLOCK_LOSS: gpio_out <= alarms_high.clock_loss;
            GPIO_SIG_FREEZE: gpio_out <= alarms_high.sig_freeze;
            GPIO_FRAMER_LOS: gpio_out <= alarms_high.framer_los;
            GPIO_ANALOG_LOS: gpio_out <= alarms_high.analog_los;
            GPIO_ALL_LOW:    gpio_out <= 8'h00;
            GPIO_ALL_HIGH:   gpio_out <= 8'hFF;
            default:         gpio_out <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interleaved bus, counter latch and interrupt pin
   // ---------------------------------------------------------------
   logic latch_bit_d_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ganged_bus_enable    <= 1'b0;
         ibo_mux_enable_high  <= 1'b0;
         ibo_mux_enable_low   <= 1'b0;
         interleave_mode_low  <= IBO_DISABLED;
         interleave_mode_high <= IBO_DISABLED;
      end
      else
      begin
         ganged_bus_enable    <= tcr_high_r[GANGED_BIT];
         interleave_mode_low  <= fpc_low_r[IBO_LSB +: 2];
         interleave_mode_high <= fpc_high_r[IBO_LSB +: 2];
         ibo_mux_enable_low   <= fpc_low_r[IBO_LSB +: 2] != IBO_DISABLED;
         ibo_mux_enable_high  <= !tcr_high_r[GANGED_BIT] &&
                                 fpc_high_r[IBO_LSB +: 2] != IBO_DISABLED;
      end
   end

   // Only a 0-to-1 edge fires; holding the bit high never repeats the latch
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         latch_bit_d_r       <= 1'b0;
         counter_latch_pulse <= 8'h00;
      end
      else
      begin
         latch_bit_d_r       <= tcr_high_r[LATCH_BIT];
         counter_latch_pulse <= (tcr_high_r[LATCH_BIT] && !latch_bit_d_r) ?
                                latch_en_r : 8'h00;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_pin_n <= 1'b1;
      else
         irq_pin_n <= tcr_high_r[INHIBIT_BIT] || !irq_request;
   end

   // ---------------------------------------------------------------
   // Per-group backplane clocks and shared pin functions
   // ---------------------------------------------------------------
   // The accumulator clocks carry up to one 20 ns period of jitter
   logic [1:0] bp_rise;

   for (genvar g = 0; g < 2; g++)
   begin : g_group
      logic [7:0]       fpc;
      logic [NCO_W-1:0] inc;
      logic [NCO_W-1:0] acc_r;
      logic             clk_q_r;
      logic [7:0]       rx_sync_r;
      logic [7:0]       tx_slot_r;
      logic [7:0]       rx_slot_r;

      assign fpc = (g == 0) ? fpc_low_r : fpc_high_r;

      always_comb
      begin
         unique case (fpc[BACKPLANE_CLOCK_SELECT_LSB +: 2])
            2'h0: inc = BP_INC_2M048;
            2'h1: inc = BP_INC_4M096;
            2'h2: inc = BP_INC_8M192;
            2'h3: inc = BP_INC_16M384;
         endcase
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            acc_r   <= '0;
            clk_q_r <= 1'b0;
         end
         else
         begin
            acc_r   <= acc_r + inc;
            clk_q_r <= acc_r[NCO_W-1];
         end
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            rx_sync_r <= 8'h00;
            tx_slot_r <= 8'h00;
            rx_slot_r <= 8'h00;
         end
         else
         begin
            rx_sync_r <= fpc[RXSYNC_BIT] ? rx_multiframe_pulse[g*8 +: 8] :
                         rx_frame_pulse[g*8 +: 8];
            tx_slot_r <= fpc[TXCH_BIT] ? tx_slot_clock[g*8 +: 8] :
                         tx_slot_block[g*8 +: 8];
            rx_slot_r <= fpc[RXCH_BIT] ? rx_slot_clock[g*8 +: 8] :
                         rx_slot_block[g*8 +: 8];
         end
      end

      assign bp_rise[g]           = acc_r[NCO_W-1] && !clk_q_r;
      assign backplane_clk[g]     = clk_q_r;
      assign rx_sync_pin[g*8 +: 8] = rx_sync_r;
      assign tx_slot_pin[g*8 +: 8] = tx_slot_r;
      assign rx_slot_pin[g*8 +: 8] = rx_slot_r;

      // Slowest rate stays high 12 or 13 cycles; a faster rate only shortens it
      a_backplane_clock_select_rate: assert property (@(posedge clk) disable iff (rst || !run_r)
         $rose(backplane_clk[g]) |-> ##[1:13] $fell(backplane_clk[g]))
         else $error("backplane clock high phase too long");
   end

   // ---------------------------------------------------------------
   // Transmit sync pins of the lower ports
   // ---------------------------------------------------------------
   // System sync is launched on the first backplane clock's rising edge
   logic [7:0] sys_sync_r;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sys_sync_r <= 8'h00;
      else if (bp_rise[0])
         sys_sync_r <= system_sync_source;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_system_sync_pin    <= 8'h00;
         tx_system_sync_pin_oe <= 8'h00;
      end
      else if (tsc_low_r[TSSEL_BIT])
      begin
         tx_system_sync_pin    <= sys_sync_r;
         tx_system_sync_pin_oe <= {8{tsc_low_r[TSDIR_BIT]}};
      end
      else
      begin
         tx_system_sync_pin    <= tx_sync_framer;
         tx_system_sync_pin_oe <= tx_sync_framer_oe;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   // Outputs still show reset values at the first edge after release
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         run_r <= 1'b0;
      else
         run_r <= 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !run_r);

   a_gpio_input_mode: assert property (!tcr_high_r[GPIO_OE_BIT] |=> gpio_oe == 8'h00)
      else $error("gpio driven while output enable clear");
   a_gpio_frame_loss: assert property (tcr_high_r[IO_PIN_OUTPUT_SELECT_LSB +: 3] == GPIO_FRAME_LOSS
      |=> gpio_out == $past(alarms_high.frame_loss))
      else $error("gpio does not follow frame loss");
   a_gpio_all_high: assert property (tcr_high_r[IO_PIN_OUTPUT_SELECT_LSB +: 3] == GPIO_ALL_HIGH
      |=> gpio_out == 8'hFF)
      else $error("gpio not all high");
   a_ganged_mux_off: assert property (tcr_high_r[GANGED_BIT] |=> !ibo_mux_enable_high)
      else $error("internal mux on while ganged");
   a_latch_on_rise: assert property ($rose(tcr_high_r[LATCH_BIT])
      |=> counter_latch_pulse == $past(latch_en_r))
      else $error("latch pulse missing after rising edge");
   a_latch_one_cycle: assert property (counter_latch_pulse != 8'h00
      |=> counter_latch_pulse == 8'h00)
      else $error("latch pulse longer than one cycle");
   a_irq_inhibit: assert property (tcr_high_r[INHIBIT_BIT] |=> irq_pin_n)
      else $error("interrupt pin low while inhibited");
   a_irq_active: assert property (!tcr_high_r[INHIBIT_BIT] && irq_request |=> !irq_pin_n)
      else $error("interrupt pin not asserted");
   a_ibo_low_on: assert property (fpc_low_r[IBO_LSB +: 2] != IBO_DISABLED
      |=> ibo_mux_enable_low)
      else $error("lower interleave mux not enabled");
   a_rx_sync_mf: assert property (fpc_high_r[RXSYNC_BIT]
      |=> rx_sync_pin[15:8] == $past(rx_multiframe_pulse[15:8]))
      else $error("receive sync pins not multiframe");
   a_tx_slot_clk: assert property (fpc_high_r[TXCH_BIT]
      |=> tx_slot_pin[15:8] == $past(tx_slot_clock[15:8]))
      else $error("transmit slot pins not clock");
   a_rx_slot_blk: assert property (!fpc_high_r[RXCH_BIT]
      |=> rx_slot_pin[15:8] == $past(rx_slot_block[15:8]))
      else $error("receive slot pins not block");
   a_sync_dir_out: assert property (tsc_low_r[TSSEL_BIT]
      |=> tx_system_sync_pin_oe == {8{$past(tsc_low_r[TSDIR_BIT])}})
      else $error("system sync direction wrong");
   a_sync_framer_sel: assert property (!tsc_low_r[TSSEL_BIT]
      |=> tx_system_sync_pin == $past(tx_sync_framer))
      else $error("framer transmit sync not selected");
   a_reserved_zero: assert property (rvalid_r && rresp_r == RESP_OKAY |-> rdata_r[31:16] == 16'h0000)
      else $error("reserved read bits not zero");

   c_latch_pulse: cover property (counter_latch_pulse != 8'h00);
   c_irq_low: cover property (!irq_pin_n);
   c_gpio_output: cover property (gpio_oe == 8'hFF && gpio_out == 8'hFF);
   c_write_done: cover property (bvalid_r && bready && bresp_r == RESP_OKAY);

endmodule

`default_nettype wire

// ---- test/tb.sv ----
// Purpose : Register and pin-function checks for the port group config block
// Assumes : Slave answers each AXI4-Lite channel by handshake, no fixed latency
// Notes   : Pin sources stay static so the pin muxes can be compared directly
`timescale 1ns/1ps
`default_nettype none
module tb
   import port_group_pkg::*;
;
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic irq_request = 1, awready, wready, bvalid, arready, rvalid, irq_pin_n;
   logic ganged_bus_enable, ibo_mux_enable_low, ibo_mux_enable_high;
   logic [1:0] bresp, rresp, interleave_mode_low, interleave_mode_high, backplane_clk, resp;
   logic [15:0] awaddr = 0, araddr = 0, rx_sync_pin, tx_slot_pin, rx_slot_pin;
   logic [31:0] wdata = 0, rdata, rdat;
   logic [3:0] wstrb = 4'hF;
   alarm_group_type alarms_high = 40'h1122334455;
   logic [7:0] gpio_in = 8'hA5, tx_system_sync_pin_in = 8'h5A, system_sync_source = 8'h96;
   logic [7:0] tx_sync_framer = 8'h3C, tx_sync_framer_oe = 8'hF0, lat_cnt = 0, lat_last = 0;
   logic [7:0] gpio_out, gpio_oe, counter_latch_pulse, tx_system_sync_pin, tx_system_sync_pin_oe;
   logic [15:0] rx_frame_pulse = 16'h1234, rx_multiframe_pulse = 16'hABCD;
   logic [15:0] tx_slot_block = 16'h0F0F, tx_slot_clock = 16'hF00F;
   logic [15:0] rx_slot_block = 16'h3333, rx_slot_clock = 16'hCCCC;
   logic [7:0] gexp [8] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h00, 8'hFF, 8'h00};
   int error_cnt = 0, checked = 0, cyc = 0;
   int bp_cnt [2] = '{0, 0};
   global_port_group_config global_port_group_config_i (.clk, .rst, .awaddr, .awvalid,
      .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .alarms_high, .gpio_in, .gpio_out, .gpio_oe,
      .irq_request, .irq_pin_n, .ganged_bus_enable, .interleave_mode_low, .interleave_mode_high,
      .ibo_mux_enable_low, .ibo_mux_enable_high, .backplane_clk, .counter_latch_pulse,
      .rx_frame_pulse, .rx_multiframe_pulse, .tx_slot_block, .tx_slot_clock, .rx_slot_block,
      .rx_slot_clock, .rx_sync_pin, .tx_slot_pin, .rx_slot_pin, .tx_sync_framer,
      .tx_sync_framer_oe, .system_sync_source, .tx_system_sync_pin_in, .tx_system_sync_pin,
      .tx_system_sync_pin_oe);
   always #10 clk = ~clk;
   always @(posedge backplane_clk[0]) bp_cnt[0]++;
   always @(posedge backplane_clk[1]) bp_cnt[1]++;
   // Latch pulses are caught here since they last one cycle only
   always @(posedge clk)
      if (|counter_latch_pulse)
      begin
         lat_cnt <= lat_cnt + 8'h01;
         lat_last <= counter_latch_pulse;
      end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         error_cnt++;
         summarize();
      end
   end
   task automatic summarize();
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   // A 20 us window holds rate times 20 us rising edges, give or take the phase
   task automatic bp_rate(input int g, input int lo, input int hi);
      int n;
      n = bp_cnt[g];
      repeat (1000) @(posedge clk);
      chk(32'h1, 32'((bp_cnt[g] - n) inside {[lo:hi]}));
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      while (!bvalid);
      bready <= 1'h0;
      resp = bresp;
      repeat (3) @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
      end
      while (!rvalid);
      rready <= 1'h0;
      rdat = rdata;
      resp = rresp;
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      foreach (gexp[i])
         if (i < 4)
         begin
            rd(i[1] ? ADDR_FPC_HIGH - 16'(i[0] * 4) : ADDR_FPC_LOW + 16'(i * 4));
            chk(32'h0, rdat);
         end
      chk(32'h0, irq_pin_n);
      chk(32'hF03C, {tx_system_sync_pin_oe, tx_system_sync_pin});
      wr(ADDR_TCR_HIGH, 8'hFF);
      rd(ADDR_TCR_HIGH);
      chk(32'hEF, rdat);
      chk(32'h1FF, {irq_pin_n, gpio_oe});
      chk(32'h1, ganged_bus_enable);
      foreach (gexp[i]) begin wr(ADDR_TCR_HIGH, {3'(i), 5'h08}); chk(gexp[i], gpio_out); end
      wr(ADDR_TCR_HIGH, 8'h00);
      chk(32'h0, {irq_pin_n, gpio_oe});
      wr(ADDR_FPC_HIGH, 8'hC7);
      wr(ADDR_FPC_LOW, 8'h40);
      chk(32'h37, {interleave_mode_high, interleave_mode_low,
                   ibo_mux_enable_high, ibo_mux_enable_low});
      bp_rate(0, 40, 41);
      chk({rx_multiframe_pulse[15:8], rx_frame_pulse[7:0]}, rx_sync_pin);
      chk({tx_slot_clock[15:8], tx_slot_block[7:0]}, tx_slot_pin);
      chk({rx_slot_clock[15:8], rx_slot_block[7:0]}, rx_slot_pin);
      wr(ADDR_TCR_HIGH, 8'h04);
      chk(32'h0, ibo_mux_enable_high);
      wr(ADDR_TSC_LOW, 8'hFF);
      rd(ADDR_TSC_LOW);
      chk(32'h3FF96, {rdat[1:0], tx_system_sync_pin_oe, tx_system_sync_pin});
      wr(ADDR_LATCH_EN, 8'h0F);
      wr(ADDR_TCR_HIGH, 8'h02);
      wr(ADDR_TCR_HIGH, 8'h02);
      chk(32'h010F, {lat_cnt, lat_last});
      wr(ADDR_TCR_HIGH, 8'h00);
      wr(ADDR_TCR_HIGH, 8'h02);
      chk(32'h020F, {lat_cnt, lat_last});
      rd(ADDR_PIN_STAT);
      chk({16'h0, tx_system_sync_pin_in, gpio_in}, rdat);
      rd(16'h0400);
      chk(RESP_SLVERR, resp);
      wr(ADDR_PIN_STAT, 8'h01);
      chk(RESP_SLVERR, resp);
      wr(ADDR_FPC_HIGH, 8'hF7);
      bp_rate(1, 327, 328);
      summarize();
   end
endmodule
`default_nettype wire
